// >>> rtl/afs_regs.svh
// register offsets, field positions and reset values of the frame-sync pin block
`ifndef AFS_REGS_SVH
`define AFS_REGS_SVH
`define AFS_OFF_CTRL 4'h0
`define AFS_OFF_GPIO 4'h4
`define AFS_OFF_STAT 4'h8
`define AFS_B_SYN 0
`define AFS_B_TX_EXT_BUFFER_ENABLE_SELECT 1
`define AFS_B_RX_FRAME_SYNC_DIRECTION 2
`define AFS_B_TX_FRAME_SYNC_DIRECTION 3
`define AFS_B_RCKD 4
`define AFS_B_NET 5
`define AFS_B_OF0 6
`define AFS_B_OF1 7
`define AFS_B_PEN 8
`define AFS_B_GDATA 6
`define AFS_CTRL_RST 9'h000
`define AFS_GPIO_RST 9'h000
`endif

// >>> rtl/afs_pkg.sv
// types of the frame-sync pin block
package afs_pkg;
    typedef enum logic [1:0]
    {
        AFS_OFF = 2'b00,
        AFS_IN = 2'b01,
        AFS_OUT = 2'b10
    } afs_pin_cfg_t;

    typedef struct packed
    {
        logic out;
        logic oe;
    } afs_pin_drv_t;

    typedef struct packed
    {
        logic [8:0] ctrl;
        logic [8:0] gpio;
        logic [2:0] s1;
        logic [2:0] s2;
        logic fs_prev;
        logic if0;
        logic if1;
        logic of0_pin;
        logic of1_pin;
        logic rx_fs;
        logic tx_fs;
        logic rx_clk;
        logic [2:0] pout;
        logic [2:0] poe;
        logic [31:0] rdata;
    } afs_state_t;
endpackage

// >>> rtl/afs_frame_sync_pins.sv
// frame-sync, serial-flag and general-purpose pin logic of the second audio port
`include "afs_regs.svh"

module afs_frame_sync_pins (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic rx_fs_gen_i,
    input wire logic tx_fs_gen_i,
    input wire logic rx_clk_gen_i,
    input wire logic tx_buf_en_i,
    input wire logic slot_i,
    input wire logic rx_frame_sync_pin_i,
    output afs_pkg::afs_pin_drv_t rx_frame_sync_pin_o,
    input wire logic tx_frame_sync_pin_i,
    output afs_pkg::afs_pin_drv_t tx_frame_sync_pin_o,
    input wire logic rx_bit_clock_pin_i,
    output afs_pkg::afs_pin_drv_t rx_bit_clock_pin_o,
    output logic rx_fs_o,
    output logic tx_fs_o,
    output logic rx_bit_clk_o,
    output logic input_flag_zero_o,
    output logic input_flag_one_o
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_ok;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_ok = rst_sync_q[1];

    // ----------------------------------------
    // state and decoded controls
    // ----------------------------------------
    afs_pkg::afs_state_t q;
    afs_pkg::afs_state_t d;
    logic en, syn, tx_ext_buffer_enable_select, rx_frame_sync_direction, tx_frame_sync_direction, rckd, net;
    logic ev;
    logic [2:0] pins_in;
    afs_pkg::afs_pin_cfg_t cfg [3];

    assign en = q.ctrl[`AFS_B_PEN];
    assign syn = q.ctrl[`AFS_B_SYN];
    assign tx_ext_buffer_enable_select = q.ctrl[`AFS_B_TX_EXT_BUFFER_ENABLE_SELECT];
    assign rx_frame_sync_direction = q.ctrl[`AFS_B_RX_FRAME_SYNC_DIRECTION];
    assign tx_frame_sync_direction = q.ctrl[`AFS_B_TX_FRAME_SYNC_DIRECTION];
    assign rckd = q.ctrl[`AFS_B_RCKD];
    assign net = q.ctrl[`AFS_B_NET];
    assign pins_in = {rx_bit_clock_pin_i, tx_frame_sync_pin_i, rx_frame_sync_pin_i};
    // flag alignment: slot strobe in network mode, frame start otherwise
    assign ev = net ? slot_i : (q.tx_fs & ~q.fs_prev);

    always_comb
    begin
        for (int i = 0; i < 3; i++)
            cfg[i] = afs_pkg::afs_pin_cfg_t'(q.gpio[2*i +: 2]);
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        d = q;
        if (ce_i)
        begin
            d.s1 = pins_in;
            d.s2 = q.s1;
            d.fs_prev = q.tx_fs;
            // register port
            if (wr_i && addr_i == `AFS_OFF_CTRL)
                d.ctrl = wdata_i[8:0];
            if (wr_i && addr_i == `AFS_OFF_GPIO)
                d.gpio = wdata_i[8:0];
            d.rdata = 32'h0;
            if (rd_i)
            begin
                case (addr_i)
                    `AFS_OFF_CTRL: d.rdata = {23'h0, q.ctrl};
                    `AFS_OFF_GPIO: d.rdata = {23'h0, q.gpio};
                    `AFS_OFF_STAT:
                    begin
                        d.rdata[0] = q.if0;
                        d.rdata[1] = q.if1;
                        for (int i = 0; i < 3; i++)
                            d.rdata[2 + i] = !en && cfg[i] == afs_pkg::AFS_IN && q.s2[i];
                    end
                    default: d.rdata = 32'h0;
                endcase
            end
            if (!en)
            begin
                // general-purpose mode
                d.rx_fs = 1'b0;
                d.tx_fs = 1'b0;
                d.rx_clk = 1'b0;
                for (int i = 0; i < 3; i++)
                begin
                    d.poe[i] = cfg[i] == afs_pkg::AFS_OUT;
                    d.pout[i] = q.gpio[`AFS_B_GDATA + i];
                end
            end
            else
            begin
                // transmit frame-sync pin
                d.poe[1] = tx_frame_sync_direction;
                d.pout[1] = tx_fs_gen_i;
                d.tx_fs = tx_frame_sync_direction ? tx_fs_gen_i : q.s2[1];
                // receive frame-sync pin
                if (!syn)
                begin
                    d.poe[0] = rx_frame_sync_direction;
                    d.pout[0] = rx_fs_gen_i;
                    d.rx_fs = rx_frame_sync_direction ? rx_fs_gen_i : q.s2[0];
                end
                else
                begin
                    d.rx_fs = d.tx_fs;
                    d.poe[0] = rx_frame_sync_direction;
                    if (tx_ext_buffer_enable_select)
                        d.pout[0] = tx_buf_en_i;
                    else
                    begin
                        d.pout[0] = q.of1_pin;
                        if (ev && rx_frame_sync_direction)
                            d.of1_pin = q.ctrl[`AFS_B_OF1];
                        if (ev && !rx_frame_sync_direction)
                            d.if1 = q.s2[0];
                    end
                end
                // receive bit-clock pin
                d.poe[2] = rckd;
                if (!syn)
                begin
                    d.pout[2] = rx_clk_gen_i;
                    d.rx_clk = rckd ? rx_clk_gen_i : q.s2[2];
                end
                else
                begin
                    d.rx_clk = 1'b0;
                    d.pout[2] = q.of0_pin;
                    if (ev && rckd)
                        d.of0_pin = q.ctrl[`AFS_B_OF0];
                    if (ev && !rckd)
                        d.if0 = q.s2[2];
                end
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_ok)
    begin
        if (!rst_ok)
        begin
            q <= '0;
            q.ctrl <= `AFS_CTRL_RST;
            q.gpio <= `AFS_GPIO_RST;
        end
        else
            q <= d;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata_o = q.rdata;
    assign rx_frame_sync_pin_o = '{out: q.pout[0], oe: q.poe[0]};
    assign tx_frame_sync_pin_o = '{out: q.pout[1], oe: q.poe[1]};
    assign rx_bit_clock_pin_o = '{out: q.pout[2], oe: q.poe[2]};
    assign rx_fs_o = q.rx_fs;
    assign tx_fs_o = q.tx_fs;
    assign rx_bit_clk_o = q.rx_clk;
    assign input_flag_zero_o = q.if0;
    assign input_flag_one_o = q.if1;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_ok);

    a_reset_quiet: assert property ($rose(rst_ok) |-> q.poe == 3'h0 && !q.ctrl[`AFS_B_PEN])
        else $error("pins not disconnected after reset");

    a_gpio_dir: assert property (ce_i && !en && cfg[0] == afs_pkg::AFS_OUT |=> q.poe[0])
        else $error("general-purpose output not driven");

    a_gpio_off: assert property (ce_i && !en && cfg[1] == afs_pkg::AFS_OFF |=> !q.poe[1])
        else $error("disconnected pin driven");

    a_async_rxfs: assert property (ce_i && en && !syn && !rx_frame_sync_direction |=> q.rx_fs == $past(q.s2[0]))
        else $error("receive frame sync not from its pin");

    a_sync_common: assert property (ce_i && en && syn |=> q.rx_fs == q.tx_fs)
        else $error("sync mode frame syncs differ");

    a_tx_dir: assert property (ce_i && en |=> q.poe[1] == $past(tx_frame_sync_direction))
        else $error("transmit frame-sync direction wrong");

    a_buf_enable: assert property (ce_i && en && syn && tx_ext_buffer_enable_select && rx_frame_sync_direction |=> q.poe[0] && q.pout[0] == $past(tx_buf_en_i))
        else $error("buffer enable not driven");

    a_flag_dir: assert property (ce_i && en && syn && !tx_ext_buffer_enable_select |=> q.poe[0] == $past(rx_frame_sync_direction))
        else $error("flag direction wrong");

    a_flag_hold: assert property (ce_i && en && syn && !tx_ext_buffer_enable_select && rx_frame_sync_direction && !ev |=> $stable(q.of1_pin))
        else $error("output flag changed off alignment");

    a_flag_capture: assert property (ce_i && en && syn && !tx_ext_buffer_enable_select && !rx_frame_sync_direction && ev |=> q.if1 == $past(q.s2[0]))
        else $error("input flag not captured");

    a_async_sck: assert property (ce_i && en && !syn && !rckd |=> q.rx_clk == $past(q.s2[2]))
        else $error("receive bit clock not from its pin");

    a_sync_depth: assert property (ce_i ##1 ce_i |=> q.s2 == $past(pins_in, 2))
        else $error("synchronizer depth wrong");

    c_flag_capture: cover property (ce_i && en && syn && !tx_ext_buffer_enable_select && !rx_frame_sync_direction && ev);
    c_gpio_out: cover property (ce_i && !en && cfg[2] == afs_pkg::AFS_OUT ##1 q.poe[2]);
    c_async_frame: cover property (en && !syn && !rx_frame_sync_direction && $rose(q.rx_fs));

endmodule

// >>> sim/afs_codec_model.sv
// behavioural audio codec on the far side of the frame-sync pins
module afs_codec_model (
    input wire logic run_i,
    input wire logic fs_i,
    input wire logic flag_i,
    input afs_pkg::afs_pin_drv_t rx_fs_pin_i,
    input afs_pkg::afs_pin_drv_t tx_fs_pin_i,
    input afs_pkg::afs_pin_drv_t sck_pin_i,
    output logic rx_fs_o,
    output logic tx_fs_o,
    output logic sck_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sck = 1'b0;
    // ----------------------------------------
    // bit clock runs only while run_i is high
    // ----------------------------------------
    always #100 sck = run_i ? ~sck : 1'b0;
    // design drives while oe is set, else codec, else the pull-down
    assign rx_fs_o = rx_fs_pin_i.oe ? rx_fs_pin_i.out : (run_i & flag_i);
    assign tx_fs_o = tx_fs_pin_i.oe ? tx_fs_pin_i.out : (run_i & fs_i);
    assign sck_o = sck_pin_i.oe ? sck_pin_i.out : sck;
endmodule

// >>> sim/afs_frame_sync_pins_tb.sv
// self-checking bench of the frame-sync pin block
module afs_frame_sync_pins_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [8:0] ctrl; logic [8:0] gpio; logic [3:0] gen; logic [5:0] exp;} afs_row_t;
    logic clock_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, slot = 1'b0, run = 1'b0, fs = 1'b0, flag = 1'b0;
    logic ce = 1'b1;
    logic [3:0] addr = 4'h0, gen = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic rxw, txw, sckw, rx_fs, tx_fs, rx_clk, if0, if1;
    afs_pkg::afs_pin_drv_t rxp, txp, sckp;
    int mismatches = 0, samples_checked = 0, n;
    afs_row_t rows [7] = '{
        '{9'h000, 9'h000, 4'h0, 6'b00_00_00},
        '{9'h000, 9'h066, 4'h0, 6'b11_00_01},
        '{9'h000, 9'h0B8, 4'h0, 6'b00_11_00},
        '{9'h11C, 9'h000, 4'h9, 6'b11_01_11},
        '{9'h100, 9'h000, 4'hF, 6'b00_00_00},
        '{9'h10F, 9'h000, 4'h6, 6'b11_11_00},
        '{9'h10F, 9'h000, 4'h2, 6'b01_11_00}};

    afs_frame_sync_pins i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_fs_gen_i(gen[0]), .tx_fs_gen_i(gen[1]), .rx_clk_gen_i(gen[3]),
        .tx_buf_en_i(gen[2]), .slot_i(slot), .rx_frame_sync_pin_i(rxw), .rx_frame_sync_pin_o(rxp),
        .tx_frame_sync_pin_i(txw), .tx_frame_sync_pin_o(txp), .rx_bit_clock_pin_i(sckw), .rx_bit_clock_pin_o(sckp),
        .rx_fs_o(rx_fs), .tx_fs_o(tx_fs), .rx_bit_clk_o(rx_clk), .input_flag_zero_o(if0), .input_flag_one_o(if1));
    afs_codec_model i_codec (.run_i(run), .fs_i(fs), .flag_i(flag), .rx_fs_pin_i(rxp), .tx_fs_pin_i(txp),
        .sck_pin_i(sckp), .rx_fs_o(rxw), .tx_fs_o(txw), .sck_o(sckw));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clock_i);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    function automatic logic [5:0] pins();
        return {rxp.out & rxp.oe, rxp.oe, txp.out & txp.oe, txp.oe, sckp.out & sckp.oe, sckp.oe};
    endfunction
    task automatic complete_run();
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial forever #12.5 clock_i = ~clock_i;
    initial
    begin
        #2ms;
        mismatches++;
        complete_run();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        tick(16);
        rst_n_i <= 1'b1;
        tick(4);
        #1 chk(pins(), 0);
        for (int i = 0; i < 7; i++)
        begin
            wr_reg(4'h0, {23'h0, rows[i].ctrl});
            wr_reg(4'h4, {23'h0, rows[i].gpio});
            gen <= rows[i].gen;
            tick(3);
            #1 chk(pins(), rows[i].exp);
        end
        tick(1);
        gen <= 4'h0;
        rd_reg(4'hC);
        chk(v, 0);
        wr_reg(4'h0, 32'h0);
        wr_reg(4'h4, 32'h5);
        run <= 1'b1;
        fs <= 1'b1;
        flag <= 1'b1;
        tick(4);
        rd_reg(4'h8);
        chk(v[3:2], 2'b11);
        wr_reg(4'h4, 32'h0);
        tick(3);
        rd_reg(4'h8);
        chk(v, 0);
        wr_reg(4'h0, 32'h100);
        fs <= 1'b0;
        flag <= 1'b0;
        tick(4);
        fs <= 1'b1;
        tick(2);
        #1 chk(tx_fs, 0);
        tick(1);
        #1 chk({rx_fs, tx_fs}, 2'b01);
        tick(1);
        flag <= 1'b1;
        tick(3);
        #1 chk(rx_fs, 1);
        n = 0;
        for (int i = 0; i < 40; i++)
        begin
            tick(1);
            n += rx_clk;
        end
        chk(n > 8 && n < 32, 1);
        wr_reg(4'h0, 32'h101);
        fs <= 1'b0;
        tick(4);
        #1 chk({rx_fs, if1, rx_clk}, 3'b000);
        tick(1);
        fs <= 1'b1;
        tick(3);
        #1 chk(rx_fs, 1);
        tick(1);
        rd_reg(4'h8);
        chk({v[1], if1}, 2'b11);
        wr_reg(4'h0, 32'h121);
        flag <= 1'b0;
        tick(4);
        #1 chk(if1, 1);
        tick(1);
        slot <= 1'b1;
        tick(1);
        slot <= 1'b0;
        tick(3);
        #1 chk(if1, 0);
        tick(1);
        fs <= 1'b0;
        wr_reg(4'h0, 32'hFFFFFF85);
        tick(4);
        #1 chk(pins() >> 4, 2'b01);
        tick(1);
        fs <= 1'b1;
        tick(5);
        #1 chk(pins() >> 4, 2'b11);
        rd_reg(4'h0);
        chk(v, 32'h185);
        tick(1);
        ce <= 1'b0;
        wr_reg(4'h0, 32'h0);
        ce <= 1'b1;
        rd_reg(4'h0);
        chk(v, 32'h185);
        tick(1);
        rst_n_i <= 1'b0;
        tick(2);
        #1 chk(pins(), 0);
        chk({if0, if1, rx_fs, tx_fs, rx_clk}, 0);
        tick(1);
        rst_n_i <= 1'b1;
        tick(4);
        rd_reg(4'h0);
        chk(v, 0);
        complete_run();
    end
endmodule
